// ===== hdl/rps_bank.sv
// Top of the RAM pointer, indirect select and configuration register bank
//
// Contract
// - Pointer high bit 7 sets access direction
// - Pointer high bit 6 enables auto advance
// - Pointer high bits 2-0 give address 10-8
// - Pointer low gives address bits 7-0
// - Select field picks indirect register view
// - Low select bits shared by both registers
// - Configuration bit 7 holds software reset
// - Software reset keeps configuration and mode
// - Software reset clears status and next id
// - Configuration bit 6 enables command queueing
// - Queueing off behaves like legacy controllers
// - Transmit gate off holds line outputs inactive, pulse B only outside backplane mode
// - Configuration bits 1-0 hold select bits
// - Configuration bit 2 selects backplane mode
`timescale 1ns/1ps
module rps_bank
  import rps_pkg::*;
#(
  parameter int AW = 11
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ramAccess,
  input  wire logic [7:0]  statusIn,
  input  wire logic [7:0]  nextIdIn,
  input  wire logic        nextIdValid,
  input  wire rps_txreq_t  txReq,
  output logic [AW-1:0]    ramAddr,
  output logic             accessDirectionRead,
  output logic [2:0]       indirectSelect,
  output logic             commandQueueOn,
  output logic             softReset,
  output logic             backplane,
  output logic [1:0]       extTimeout,
  output rps_line_t        line
);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  localparam logic [2:0] SLOT_PTR_HIGH = 3'h0;
  localparam logic [2:0] SLOT_PTR_LOW  = 3'h1;
  localparam logic [2:0] SLOT_SELECT   = 3'h2;
  localparam logic [2:0] SLOT_CONFIG   = 3'h3;
  localparam logic [2:0] SLOT_STATUS   = 3'h4;
  localparam logic [2:0] SLOT_ACCESS   = 3'h5;
  localparam logic [2:0] SLOT_NONE     = 3'h7;

  // Map a byte address onto a register slot; shared by write decode, read mux and window advance
  function automatic logic [2:0] regSlot(input logic [11:0] addr);
    logic [2:0] hit;
    hit = SLOT_NONE;
    if (addr == RPS_PTR_HIGH_ADDR) begin
      hit = SLOT_PTR_HIGH;
    end else if (addr == RPS_PTR_LOW_ADDR) begin
      hit = SLOT_PTR_LOW;
    end else if (addr == RPS_SELECT_ADDR) begin
      hit = SLOT_SELECT;
    end else if (addr == RPS_CONFIG_ADDR) begin
      hit = SLOT_CONFIG;
    end else if (addr == RPS_STATUS_ADDR) begin
      hit = SLOT_STATUS;
    end else if (addr == RPS_ACCESS_ADDR) begin
      hit = SLOT_ACCESS;
    end
    return hit;
  endfunction

  logic        access;
  logic        done;
  logic        wrEn;
  logic        rdEn;
  logic        wrHigh;
  logic        wrLow;
  logic        wrSel;
  logic        wrCfg;
  logic        mapped;
  logic [2:0]  slot;
  logic [7:0]  wd;
  logic        ready_q;
  logic        slvErr_q;
  logic [31:0] rdata_q;

  // Access phase; a transfer ends at the edge where the registered ready is high
  assign access = psel && penable;
  assign done   = access && ready_q;
  assign wrEn   = done && pwrite;
  assign rdEn   = access && !pwrite;
  assign wd     = pwdata[7:0];
  assign slot   = regSlot(paddr);
  assign mapped = (slot != SLOT_NONE);

  // Write strobes, one per writable register; status and window take no write
  always_comb begin
    wrHigh = 1'b0;
    wrLow  = 1'b0;
    wrSel  = 1'b0;
    wrCfg  = 1'b0;
    if (slot == SLOT_PTR_HIGH) begin
      wrHigh = wrEn;
    end else if (slot == SLOT_PTR_LOW) begin
      wrLow = wrEn;
    end else if (slot == SLOT_SELECT) begin
      wrSel = wrEn;
    end else if (slot == SLOT_CONFIG) begin
      wrCfg = wrEn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and select registers

  logic       srst_q;
  logic       queue_q;
  logic       gate_q;
  logic [1:0] et_q;
  logic       bpl_q;
  logic [1:0] selLow_q;
  logic       selTop_q;
  logic [7:0] cfgRead;

  // Configuration bits are reset only by hardware reset, never by soft reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      srst_q  <= RPS_CONFIG_RST[RPS_SRST_BIT];
      queue_q <= RPS_CONFIG_RST[RPS_QUEUE_BIT];
      gate_q  <= RPS_CONFIG_RST[RPS_GATE_BIT];
      et_q    <= RPS_CONFIG_RST[4:3];
      bpl_q   <= RPS_CONFIG_RST[RPS_BPL_BIT];
    end else if (wrCfg) begin
      srst_q  <= wd[RPS_SRST_BIT];
      queue_q <= wd[RPS_QUEUE_BIT];
      gate_q  <= wd[RPS_GATE_BIT];
      et_q    <= wd[4:3];
      bpl_q   <= wd[RPS_BPL_BIT];
    end
  end

  // One shared store for the low select bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selLow_q <= RPS_SEL_RST[1:0];
    end else if (wrCfg || wrSel) begin
      selLow_q <= wd[1:0];
    end
  end

  // Top select bit, cleared by any configuration write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selTop_q <= RPS_SEL_RST[2];
    end else if (wrCfg) begin
      selTop_q <= 1'b0;
    end else if (wrSel) begin
      selTop_q <= wd[2];
    end
  end

  assign cfgRead = {srst_q, queue_q, gate_q, et_q, bpl_q, selLow_q};

  ////////////////////////////////////////////////////////////////////////////
  // Registers set by software reset

  logic [7:0] status_q;
  logic [7:0] nextId_q;

  // Status and next id initialised while soft reset is held
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= RPS_STATUS_RST;
      nextId_q <= RPS_NEXTID_RST;
    end else if (srst_q) begin
      status_q <= RPS_STATUS_RST;
      nextId_q <= RPS_NEXTID_RST;
    end else begin
      status_q <= statusIn;
      if (nextIdValid) begin
        nextId_q <= nextIdIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer

  logic [AW-1:0] ptrAddr;
  logic          ptrDir;
  logic          ptrInc;
  logic [2:0]    ptrSpare;
  logic          dataStep;

  // A data access from the RAM port or an APB data window access advances
  assign dataStep = ramAccess || (done && slot == SLOT_ACCESS);

  rps_pointer #(
    .AW (AW)
  ) uPointer (
    .clk                 (clk),
    .reset_n             (reset_n),
    .wrHigh              (wrHigh),
    .wrLow               (wrLow),
    .wdata               (wd),
    .dataAccess          (dataStep),
    .ramAddr             (ptrAddr),
    .accessDirectionRead (ptrDir),
    .pointerAutoAdvance  (ptrInc),
    .spareBits           (ptrSpare)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Line gate

  rps_line_gate uGate (
    .clk          (clk),
    .reset_n      (reset_n),
    .transmitGate (gate_q),
    .backplane    (bpl_q),
    .softReset    (srst_q),
    .txReq        (txReq),
    .line         (line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and APB answer

  logic [7:0] rdByte;

  // Read data select
  always_comb begin
    rdByte = 8'h00;
    if (slot == SLOT_PTR_HIGH) begin
      rdByte = {ptrDir, ptrInc, ptrSpare, ptrAddr[AW-1:8]};
    end else if (slot == SLOT_PTR_LOW) begin
      rdByte = ptrAddr[7:0];
    end else if (slot == SLOT_SELECT) begin
      rdByte = {5'h00, selTop_q, selLow_q};
    end else if (slot == SLOT_CONFIG) begin
      rdByte = cfgRead;
    end else if (slot == SLOT_STATUS) begin
      rdByte = status_q;
    end else if (slot == SLOT_ACCESS) begin
      rdByte = nextId_q;
    end
  end

  // One wait state: ready rises after the first access cycle and falls after the ending edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= access && !ready_q;
    end
  end

  // Read data captured in the first access cycle and shown only while ready stands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rdEn && !ready_q) begin
      rdata_q <= {24'h00_0000, rdByte};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // Error answer for an address outside the map, standing with ready
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slvErr_q <= 1'b0;
    end else begin
      slvErr_q <= access && !ready_q && !mapped;
    end
  end

  // Bus answer straight from registers
  assign pready  = ready_q;
  assign pslverr = slvErr_q;
  assign prdata  = rdata_q;

  // Block outputs from registers
  assign ramAddr             = ptrAddr;
  assign accessDirectionRead = ptrDir;
  assign indirectSelect      = {selTop_q, selLow_q};
  assign commandQueueOn      = queue_q;
  assign softReset           = srst_q;
  assign backplane           = bpl_q;
  assign extTimeout          = et_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Configuration write clears the top select bit
  sel_top_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrCfg |=> (selTop_q == 1'b0))
    else $error("top select bit not cleared");
  // Select write and configuration view agree
  sel_shared_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrSel |=> (cfgRead[1:0] == $past(wd[1:0])))
    else $error("shared select bits differ");
  // Soft reset holds status and next id at zero
  soft_reset_init_a: assert property (@(posedge clk) disable iff (!reset_n)
    srst_q |=> (status_q == 8'h00 && nextId_q == 8'h00))
    else $error("soft reset did not initialise");
  // Soft reset keeps configuration
  soft_reset_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    (srst_q && !wrCfg && !wrSel) |=> $stable(cfgRead))
    else $error("soft reset changed configuration");
  // Soft reset persists until cleared by a write
  soft_reset_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (srst_q && !wrCfg) |=> srst_q)
    else $error("soft reset released on its own");
  // Direction follows pointer high write
  dir_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrHigh |=> (accessDirectionRead == $past(wd[RPS_DIR_BIT])))
    else $error("direction bit not stored");
  // Queue enable follows configuration write
  queue_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrCfg |=> (commandQueueOn == $past(wd[RPS_QUEUE_BIT])))
    else $error("queue enable not stored");
  // Pointer high write loads the upper address bits
  ptr_high_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrHigh |=> (ptrAddr[AW-1:8] == $past(wd[2:0])))
    else $error("upper address bits not loaded");
  // Pointer low write loads the lower address bits
  ptr_low_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrLow |=> (ptrAddr[7:0] == $past(wd)))
    else $error("lower address bits not loaded");
  // A data window transfer with auto advance moves the pointer by one
  window_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    (done && slot == SLOT_ACCESS && ptrInc && !ramAccess) |=> (ptrAddr == $past(ptrAddr) + AW'(1)))
    else $error("window access did not advance once");

endmodule

// ===== hdl/rps_pkg.sv
// Package with register map, field layout and types of the pointer and configuration bank
package rps_pkg;

  // Register byte addresses on APB
  localparam logic [11:0] RPS_PTR_HIGH_ADDR = 12'h000;
  localparam logic [11:0] RPS_PTR_LOW_ADDR  = 12'h004;
  localparam logic [11:0] RPS_SELECT_ADDR   = 12'h008;
  localparam logic [11:0] RPS_CONFIG_ADDR   = 12'h00C;
  localparam logic [11:0] RPS_STATUS_ADDR   = 12'h010;
  localparam logic [11:0] RPS_ACCESS_ADDR   = 12'h014;

  // Pointer high field positions
  localparam int RPS_DIR_BIT  = 7;
  localparam int RPS_AINC_BIT = 6;

  // Configuration field positions
  localparam int RPS_SRST_BIT  = 7;
  localparam int RPS_QUEUE_BIT = 6;
  localparam int RPS_GATE_BIT  = 5;
  localparam int RPS_BPL_BIT   = 2;

  // Values after reset
  localparam logic [7:0] RPS_CONFIG_RST = 8'h00;
  localparam logic [7:0] RPS_PTRH_RST   = 8'h00;
  localparam logic [7:0] RPS_PTRL_RST   = 8'h00;
  localparam logic [2:0] RPS_SEL_RST    = 3'h0;
  localparam logic [7:0] RPS_STATUS_RST = 8'h00;
  localparam logic [7:0] RPS_NEXTID_RST = 8'h00;

  // Indirect register selection codes
  typedef enum logic [2:0] {
    RPS_SEL_TENT_ID  = 3'b000,
    RPS_SEL_NODE_ID  = 3'b001,
    RPS_SEL_SETUP1   = 3'b010,
    RPS_SEL_NEXT_ID  = 3'b011,
    RPS_SEL_SETUP2   = 3'b100,
    RPS_SEL_RSVD5    = 3'b101,
    RPS_SEL_RSVD6    = 3'b110,
    RPS_SEL_RSVD7    = 3'b111
  } rps_sel_t;

  // Line outputs, all active low
  typedef struct packed {
    logic linePulseAN;
    logic linePulseBN;
    logic driverEnableN;
  } rps_line_t;

  // Request from the protocol engine to drive the line
  typedef struct packed {
    logic pulseA;
    logic pulseB;
    logic driverOn;
  } rps_txreq_t;

endpackage

// ===== hdl/rps_pointer.sv
// Eleven-bit RAM address pointer with auto advance
`timescale 1ns/1ps
module rps_pointer
  import rps_pkg::*;
#(
  parameter int AW = 11
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          wrHigh,
  input  wire logic          wrLow,
  input  wire logic [7:0]    wdata,
  input  wire logic          dataAccess,
  output logic [AW-1:0]      ramAddr,
  output logic               accessDirectionRead,
  output logic               pointerAutoAdvance,
  output logic [2:0]         spareBits
);

  logic [AW-1:0] addr_q;
  logic          dir_q;
  logic          ainc_q;
  logic [2:0]    spare_q;

  // Pointer load and advance; a write wins over an advance in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= {RPS_PTRH_RST[2:0], RPS_PTRL_RST};
    end else if (wrHigh) begin
      addr_q <= {wdata[2:0], addr_q[7:0]};
    end else if (wrLow) begin
      addr_q <= {addr_q[AW-1:8], wdata};
    end else if (dataAccess && ainc_q) begin
      addr_q <= addr_q + AW'(1);
    end
  end

  // Direction and advance control
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_q   <= RPS_PTRH_RST[RPS_DIR_BIT];
      ainc_q  <= RPS_PTRH_RST[RPS_AINC_BIT];
      spare_q <= RPS_PTRH_RST[5:3];
    end else if (wrHigh) begin
      dir_q   <= wdata[RPS_DIR_BIT];
      ainc_q  <= wdata[RPS_AINC_BIT];
      spare_q <= wdata[5:3];
    end
  end

  assign ramAddr             = addr_q;
  assign accessDirectionRead = dir_q;
  assign pointerAutoAdvance  = ainc_q;
  assign spareBits           = spare_q;

  // Advance wraps from the top address to zero
  pointer_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!wrHigh && !wrLow && dataAccess && ainc_q && addr_q == {AW{1'b1}}) |=> addr_q == '0)
    else $error("pointer did not wrap");
  // Pointer holds without auto advance
  pointer_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!wrHigh && !wrLow && !ainc_q) |=> $stable(addr_q))
    else $error("pointer moved without advance");

endmodule

// ===== hdl/rps_line_gate.sv
// Output stage that gates the line drivers with the transmit enable
`timescale 1ns/1ps
module rps_line_gate
  import rps_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       transmitGate,
  input  wire logic       backplane,
  input  wire logic       softReset,
  input  wire rps_txreq_t txReq,
  output rps_line_t       line
);

  rps_line_t line_q;
  rps_line_t line_d;

  // Line outputs held inactive (high) while transmission is gated off, pulse B only outside backplane mode
  always_comb begin
    line_d.linePulseAN   = ~(transmitGate && !softReset && txReq.pulseA);
    line_d.driverEnableN = ~(transmitGate && !softReset && txReq.driverOn);
    // In backplane mode the second pulse output is not gated
    line_d.linePulseBN   = backplane ? ~txReq.pulseB
                                     : ~(transmitGate && !softReset && txReq.pulseB);
  end

  // Registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_q <= '1;
    end else begin
      line_q <= line_d;
    end
  end

  assign line = line_q;

  // Gated outputs stay inactive while the gate is off
  line_gated_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!transmitGate) |=> (line_q.linePulseAN && line_q.driverEnableN))
    else $error("line driven while gate off");
  // Second pulse gated outside backplane mode
  pulse_b_gated_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!transmitGate && !backplane) |=> line_q.linePulseBN)
    else $error("second pulse driven while gated");

endmodule

// ===== test/rps_host_model.sv
// Host bus master model that reaches the register bank over APB
`timescale 1ns/1ps
module rps_host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // One transfer: setup cycle, then access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [7:0] wdat,
                      output logic [7:0] rdat, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'h00_0000, wdat};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata[7:0];
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench of the pointer, select and configuration bank
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb_top
  import rps_pkg::*;
;
  logic        clk;
  logic        resetN;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        ramAccess, nextIdValid;
  logic [7:0]  statusIn, nextIdIn;
  rps_txreq_t  txReq;
  logic [10:0] ramAddr;
  logic        accessDirectionRead, commandQueueOn, softReset, backplane;
  logic [2:0]  indirectSelect;
  logic [1:0]  extTimeout;
  rps_line_t   line;
  int          mismatches;
  int          comparisons;
  int          cycles;
  logic [7:0]  rdat;
  logic        err;

  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end

  rps_bank dut_u (.clk(clk), .reset_n(resetN), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ramAccess(ramAccess), .statusIn(statusIn), .nextIdIn(nextIdIn), .nextIdValid(nextIdValid),
    .txReq(txReq), .ramAddr(ramAddr), .accessDirectionRead(accessDirectionRead),
    .indirectSelect(indirectSelect), .commandQueueOn(commandQueueOn), .softReset(softReset),
    .backplane(backplane), .extTimeout(extTimeout), .line(line));

  rps_host_model host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////
  // Bus and stimulus helpers
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, rdat, err);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
    host_u.xfer(1'b0, a, 8'h00, rdat, err);
    `CHK(rdat, e)
  endtask
  task automatic pulse();
    @(posedge clk);
    ramAccess <= 1'b1;
    @(posedge clk);
    ramAccess <= 1'b0;
    @(negedge clk);
  endtask
  task automatic endTest(input string name);
    $display("Test %s finished", name);
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    resetN = 1'b0;
    ramAccess = 1'b0;
    statusIn = 8'h00;
    nextIdIn = 8'h00;
    nextIdValid = 1'b0;
    txReq = '0;
    repeat (4) @(posedge clk);
    resetN <= 1'b1;
    rdChk(RPS_PTR_HIGH_ADDR, RPS_PTRH_RST);
    rdChk(RPS_CONFIG_ADDR, RPS_CONFIG_RST);
    @(negedge clk);
    `CHK(line, 3'b111)
    endTest("reset");
    // Pointer fields, advance with carry and wrap, hold without advance
    wr(RPS_PTR_HIGH_ADDR, 8'hC5);
    wr(RPS_PTR_LOW_ADDR, 8'hFF);
    rdChk(RPS_PTR_HIGH_ADDR, 8'hC5);
    @(negedge clk);
    `CHK(ramAddr, 11'h5FF)
    `CHK(accessDirectionRead, 1'b1)
    pulse();
    `CHK(ramAddr, 11'h600)
    wr(RPS_PTR_HIGH_ADDR, 8'h47);
    wr(RPS_PTR_LOW_ADDR, 8'hFF);
    pulse();
    `CHK(ramAddr, 11'h000)
    `CHK(accessDirectionRead, 1'b0)
    wr(RPS_PTR_HIGH_ADDR, 8'h03);
    pulse();
    `CHK(ramAddr, 11'h300)
    wr(RPS_PTR_HIGH_ADDR, 8'h43);
    rdChk(RPS_ACCESS_ADDR, 8'h00);
    @(negedge clk);
    `CHK(ramAddr, 11'h301)
    wr(RPS_PTR_HIGH_ADDR, 8'h03);
    endTest("pointer");
    // Every select code, shared low bits, top bit cleared by configuration write
    for (int i = 0; i < 8; i++) begin
      wr(RPS_SELECT_ADDR, i[7:0]);
      rdChk(RPS_CONFIG_ADDR, {6'h00, i[1:0]});
      rdChk(RPS_SELECT_ADDR, {5'h00, i[2:0]});
      `CHK(indirectSelect, i[2:0])
    end
    wr(RPS_CONFIG_ADDR, 8'h03);
    @(negedge clk);
    `CHK(indirectSelect, 3'b011)
    endTest("select");
    // Configuration fields
    wr(RPS_CONFIG_ADDR, 8'h5C);
    rdChk(RPS_CONFIG_ADDR, 8'h5C);
    `CHK(commandQueueOn, 1'b1)
    `CHK(backplane, 1'b1)
    `CHK(extTimeout, 2'b11)
    wr(RPS_CONFIG_ADDR, 8'h18);
    @(negedge clk);
    `CHK(commandQueueOn, 1'b0)
    endTest("config");
    // Transmit gating of the line outputs
    @(posedge clk);
    txReq <= '1;
    repeat (2) @(negedge clk);
    `CHK(line, 3'b111)
    wr(RPS_CONFIG_ADDR, 8'h04);
    repeat (2) @(negedge clk);
    `CHK(line, 3'b101)
    wr(RPS_CONFIG_ADDR, 8'h20);
    repeat (2) @(negedge clk);
    `CHK(line, 3'b000)
    endTest("gate");
    // Software reset hold and release
    @(posedge clk);
    statusIn <= 8'h5A;
    nextIdIn <= 8'h3C;
    nextIdValid <= 1'b1;
    @(posedge clk);
    nextIdValid <= 1'b0;
    rdChk(RPS_STATUS_ADDR, 8'h5A);
    rdChk(RPS_ACCESS_ADDR, 8'h3C);
    wr(RPS_CONFIG_ADDR, 8'hA0);
    rdChk(RPS_STATUS_ADDR, 8'h00);
    rdChk(RPS_ACCESS_ADDR, 8'h00);
    rdChk(RPS_CONFIG_ADDR, 8'hA0);
    rdChk(RPS_PTR_HIGH_ADDR, 8'h03);
    `CHK(softReset, 1'b1)
    wr(RPS_CONFIG_ADDR, 8'h20);
    rdChk(RPS_STATUS_ADDR, 8'h5A);
    `CHK(softReset, 1'b0)
    endTest("softreset");
    // Unmapped address is refused and reads zero
    host_u.xfer(1'b0, 12'h020, 8'h00, rdat, err);
    `CHK(err, 1'b1)
    `CHK(rdat, 8'h00)
    endTest("unmapped");
    test_done();
  end
endmodule
